// *** rtl/tile_boot_regs.vh ***
/*
 constants for the tile boot loader: strap codes, timing counts, link tokens, usercode fields.
 assumes a 10 MHz core clock.
*/
`ifndef TILE_BOOT_REGS_VH
`define TILE_BOOT_REGS_VH
`define CLK_MHZ 10
`define INIT_TIME_US 15
`define INIT_CYCLES 8'd150
`define LINK_EN_TIME_US 2
`define LINK_EN_CYCLES 8'd20
`define STRAP_QSPI 3'h0
`define STRAP_SPI_MASTER 3'h1
`define STRAP_SPI_SLAVE_A 3'h2
`define STRAP_SPI_SLAVE_B 3'h3
`define STRAP_LINK 3'h4
`define SRC_NONE 3'h0
`define SRC_QSPI 3'h1
`define SRC_SPI_MASTER 3'h2
`define SRC_SPI_SLAVE 3'h3
`define SRC_LINK 3'h4
`define SRC_OTP 3'h5
`define SEC_OTP_BOOT_BIT 5
`define SEC_USER_ID_LSB 22
`define SEC_USER_ID_MSB 31
`define USERCODE_REV_W 16
`define NULL_CHANEND 32'h0000ff02
`define TOKEN_END 8'h01
`define LINK_BITS 2
`endif

// *** rtl/boot_word_buffer.v ***
/*
 two-entry word buffer with valid/ready on both sides.
 assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ns
module boot_word_buffer (
    input wire clk_i,
    input wire resetn_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [31:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [31:0] out_data_o
);
    reg [31:0] mem_q [0:1];
    reg wr_q;
    reg rd_q;
    reg [1:0] cnt_q;
    wire push = in_valid_i && (cnt_q != 2'h2);
    wire pop = out_ready_i && (cnt_q != 2'h0);
    assign in_ready_o = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = mem_q[rd_q];
    always @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
        if (!resetn_i) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // boot_word_buffer

// *** rtl/tile_boot_loader.v ***
/*
 reset release, boot source selection, spi slave and link image loading, usercode.
 assumes a 10 MHz clk_i; all pins are asynchronous and synchronised here.
*/
`timescale 1ns/1ns
`include "tile_boot_regs.vh"
// Contract
// - hold in reset; boot after init delay
// - pull-downs on all gpio in reset
// - ports attach to clock block zero
// - otp bit 5 overrides strap source
// - straps choose boot source, link only 100
// - image: size word then s words
// - spi slave modes 0/0 and 1/1 only
// - spi slave bytes arrive lsb first
// - link runs two-wire or five-wire mode
// - links enabled about 2 us after start
// - link enable: pulls off, tx low, watch
// - first link word names ack channel
// - image then end token on chanend zero
// - send end ack, free chanend, run
// - usercode: user id, unused, revision
// - user id from otp bits 22..31
module tile_boot_loader (
    input wire clk_i,
    input wire resetn_i,
    input wire boot_strap_bit2_i,
    input wire boot_strap_bit1_i,
    input wire boot_strap_bit0_i,
    input wire [31:0] otp_security_i,
    input wire [15:0] silicon_rev_i,
    input wire boot_slave_select_pin_i,
    input wire boot_slave_clock_pin_i,
    input wire boot_slave_data_pin_i,
    input wire spi_cpol_i,
    input wire link_five_wire_i,
    input wire link_zero_clk_i,
    input wire [1:0] link_zero_rx_i,
    input wire prog_ready_i,
    output reg gpio_pulldown_o,
    output reg [2:0] port_clock_block_o,
    output reg [2:0] boot_source_o,
    output reg spi_slave_pins_en_o,
    output reg link_zero_en_o,
    output reg link_zero_pulldown_o,
    output reg [1:0] link_zero_tx_o,
    output reg link_zero_tx_oe_o,
    output reg link_five_wire_o,
    output reg chanend0_alloc_o,
    output reg [31:0] ack_chanend_o,
    output reg ack_token_valid_o,
    output reg [7:0] ack_token_o,
    output reg prog_valid_o,
    output reg [31:0] prog_word_o,
    output reg [31:0] prog_size_o,
    output reg boot_done_o,
    output reg run_o,
    output reg [31:0] usercode_o
);
    localparam ST_INIT = 3'h0;
    localparam ST_SEL = 3'h1;
    localparam ST_LINK_WAIT = 3'h2;
    localparam ST_LOAD = 3'h3;
    localparam ST_END = 3'h4;
    localparam ST_RUN = 3'h5;
    localparam LD_ACK = 2'h0;
    localparam LD_SIZE = 2'h1;
    localparam LD_PROG = 2'h2;
    localparam LD_CRC = 2'h3;

    // high in the cycle that the current sample is 1 while the delayed sample is still 0
    function rise;
        input cur;
        input prev;
        begin
            rise = cur & ~prev;
        end
    endfunction

    reg [2:0] strap_m_q, strap_q;
    reg ss_m_q, ss_q, ss_d1_q;
    reg sck_m_q, sck_q, sck_d1_q;
    reg mosi_m_q, mosi_q;
    reg lclk_m_q, lclk_q, lclk_d1_q;
    reg [1:0] lrx_m_q, lrx_q;
    reg [2:0] state_q;
    reg [1:0] ld_q;
    reg [7:0] timer_q;
    reg [7:0] shift_q;
    reg [2:0] bit_q;
    reg [31:0] word_q;
    reg [1:0] byte_q;
    reg word_valid_q;
    reg [31:0] count_q;
    reg [7:0] tok_q;
    reg [3:0] tok_bits_q;
    reg tok_mode_q;
    reg sck_armed_q;

    wire buf_in_ready;
    wire buf_out_valid;
    wire [31:0] buf_out_data;
    wire ss_active = ~ss_q;
    wire sck_sample = rise(sck_q, sck_d1_q) & sck_armed_q;
    wire lclk_edge = rise(lclk_q, lclk_d1_q);
    wire fill_en = (state_q == ST_LOAD);
    wire [7:0] spi_byte = {mosi_q, shift_q[7:1]};
    wire is_spi = (boot_source_o == `SRC_SPI_SLAVE);
    wire is_link = (boot_source_o == `SRC_LINK);

    boot_word_buffer u_buf (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(word_valid_q),
        .in_ready_o(buf_in_ready),
        .in_data_i(word_q),
        .out_valid_o(buf_out_valid),
        .out_ready_i(fill_en && (ld_q == LD_ACK || ld_q == LD_SIZE || ld_q == LD_CRC || prog_ready_i)),
        .out_data_o(buf_out_data)
    );

    // pin synchronisers
    always @(posedge clk_i) begin
        strap_m_q <= {boot_strap_bit2_i, boot_strap_bit1_i, boot_strap_bit0_i};
        strap_q <= strap_m_q;
        ss_m_q <= boot_slave_select_pin_i;
        ss_q <= ss_m_q;
        ss_d1_q <= ss_q;
        sck_m_q <= boot_slave_clock_pin_i;
        sck_q <= sck_m_q;
        sck_d1_q <= sck_q;
        mosi_m_q <= boot_slave_data_pin_i;
        mosi_q <= mosi_m_q;
        lclk_m_q <= link_zero_clk_i;
        lclk_q <= lclk_m_q;
        lclk_d1_q <= lclk_q;
        lrx_m_q <= link_zero_rx_i;
        lrx_q <= lrx_m_q;
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            gpio_pulldown_o <= 1'b1;
            port_clock_block_o <= 3'h0;
            boot_source_o <= `SRC_NONE;
            spi_slave_pins_en_o <= 1'b0;
            link_zero_en_o <= 1'b0;
            link_zero_pulldown_o <= 1'b1;
            link_zero_tx_o <= 2'h0;
            link_zero_tx_oe_o <= 1'b0;
            link_five_wire_o <= 1'b0;
            chanend0_alloc_o <= 1'b0;
            ack_chanend_o <= `NULL_CHANEND;
            ack_token_valid_o <= 1'b0;
            ack_token_o <= 8'h00;
            prog_valid_o <= 1'b0;
            prog_word_o <= 32'h0;
            prog_size_o <= 32'h0;
            boot_done_o <= 1'b0;
            run_o <= 1'b0;
            usercode_o <= 32'h0;
            state_q <= ST_INIT;
            ld_q <= LD_ACK;
            timer_q <= 8'h0;
            shift_q <= 8'h0;
            bit_q <= 3'h0;
            word_q <= 32'h0;
            byte_q <= 2'h0;
            word_valid_q <= 1'b0;
            count_q <= 32'h0;
            tok_q <= 8'h0;
            tok_bits_q <= 4'h0;
            tok_mode_q <= 1'b0;
            sck_armed_q <= 1'b0;
        end else begin
            usercode_o <= {otp_security_i[`SEC_USER_ID_MSB:`SEC_USER_ID_LSB],
                6'h0, silicon_rev_i};
            prog_valid_o <= 1'b0;
            ack_token_valid_o <= 1'b0;
            if (word_valid_q && buf_in_ready) begin
                word_valid_q <= 1'b0;
            end
            case (state_q)
                ST_INIT: begin
                    timer_q <= timer_q + 8'h1;
                    if (timer_q == `INIT_CYCLES) begin
                        gpio_pulldown_o <= 1'b0;
                        timer_q <= 8'h0;
                        state_q <= ST_SEL;
                    end
                end
                ST_SEL: begin
                    if (otp_security_i[`SEC_OTP_BOOT_BIT]) begin
                        boot_source_o <= `SRC_OTP;
                        state_q <= ST_END;
                    end else begin
                        case (strap_q)
                            `STRAP_QSPI: begin
                                boot_source_o <= `SRC_QSPI;
                                state_q <= ST_END;
                            end
                            `STRAP_SPI_MASTER: begin
                                boot_source_o <= `SRC_SPI_MASTER;
                                state_q <= ST_END;
                            end
                            `STRAP_SPI_SLAVE_A, `STRAP_SPI_SLAVE_B: begin
                                boot_source_o <= `SRC_SPI_SLAVE;
                                spi_slave_pins_en_o <= 1'b1;
                                state_q <= ST_LOAD;
                            end
                            `STRAP_LINK: begin
                                boot_source_o <= `SRC_LINK;
                                state_q <= ST_LINK_WAIT;
                            end
                            default: begin
                                boot_source_o <= `SRC_NONE;
                                state_q <= ST_END;
                            end
                        endcase
                    end
                end
                ST_LINK_WAIT: begin
                    timer_q <= timer_q + 8'h1;
                    if (timer_q == `LINK_EN_CYCLES) begin
                        link_zero_en_o <= 1'b1;
                        link_zero_pulldown_o <= 1'b0;
                        link_zero_tx_o <= 2'h0;
                        link_zero_tx_oe_o <= 1'b1;
                        link_five_wire_o <= link_five_wire_i;
                        chanend0_alloc_o <= 1'b1;
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // spi slave byte assembly
                    if (is_spi) begin
                        sck_armed_q <= ss_active && (sck_armed_q || (sck_q == spi_cpol_i));
                        if (!ss_active || rise(ss_q, ss_d1_q) || (ss_d1_q & ~ss_q)) begin
                            bit_q <= 3'h0;
                            byte_q <= 2'h0;
                        end else if (sck_sample && !word_valid_q) begin
                            shift_q <= spi_byte;
                            bit_q <= bit_q + 3'h1;
                            if (bit_q == 3'h7) begin
                                word_q <= {spi_byte, word_q[31:8]};
                                byte_q <= byte_q + 2'h1;
                                if (byte_q == 2'h3) begin
                                    word_valid_q <= 1'b1;
                                end
                            end
                        end
                    end
                    // link: two bits per rising link clock edge, lsb first
                    if (is_link && lclk_edge && !word_valid_q) begin
                        if (tok_mode_q) begin
                            tok_q <= {lrx_q, tok_q[7:2]};
                            tok_bits_q <= tok_bits_q + 4'h2;
                            if (tok_bits_q == 4'h6 && {lrx_q, tok_q[7:2]} == `TOKEN_END) begin
                                state_q <= ST_END;
                            end
                        end else begin
                            word_q <= {lrx_q, word_q[31:2]};
                            shift_q <= shift_q + 8'h1;
                            if (shift_q == 8'd15) begin
                                shift_q <= 8'h0;
                                word_valid_q <= 1'b1;
                            end
                        end
                    end
                    if (buf_out_valid) begin
                        case (ld_q)
                            LD_ACK: begin
                                if (is_link) begin
                                    ack_chanend_o <= buf_out_data;
                                    ld_q <= LD_SIZE;
                                end else begin
                                    prog_size_o <= buf_out_data;
                                    count_q <= buf_out_data;
                                    ld_q <= LD_PROG;
                                    if (buf_out_data == 32'h0) begin
                                        state_q <= ST_END;
                                    end
                                end
                            end
                            LD_SIZE: begin
                                prog_size_o <= buf_out_data;
                                count_q <= buf_out_data;
                                ld_q <= (buf_out_data == 32'h0) ? LD_CRC : LD_PROG;
                            end
                            LD_PROG: begin
                                if (prog_ready_i) begin
                                    prog_valid_o <= 1'b1;
                                    prog_word_o <= buf_out_data;
                                    count_q <= count_q - 32'h1;
                                    if (count_q == 32'h1) begin
                                        if (is_link) begin
                                            ld_q <= LD_CRC;
                                        end else begin
                                            state_q <= ST_END;
                                        end
                                    end
                                end
                            end
                            LD_CRC: begin
                                tok_mode_q <= 1'b1;
                                tok_bits_q <= 4'h0;
                            end
                            default: begin
                                ld_q <= LD_ACK;
                            end
                        endcase
                    end
                end
                ST_END: begin
                    if (is_link) begin
                        if (ack_chanend_o != `NULL_CHANEND) begin
                            ack_token_valid_o <= 1'b1;
                            ack_token_o <= `TOKEN_END;
                        end
                        chanend0_alloc_o <= 1'b0;
                    end
                    boot_done_o <= 1'b1;
                    state_q <= ST_RUN;
                end
                ST_RUN: begin
                    run_o <= 1'b1;
                end
                default: begin
                    state_q <= ST_INIT;
                end
            endcase
        end
    end
endmodule // tile_boot_loader

// *** verification/tile_boot_loader_asserts.sv ***
/*
 port checks for the tile boot loader.
 assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module tile_boot_loader_checker (
    input wire clk_i,
    input wire resetn_i,
    input wire [31:0] otp_security_i,
    input wire [15:0] silicon_rev_i,
    input wire gpio_pulldown_o,
    input wire [2:0] port_clock_block_o,
    input wire [2:0] boot_source_o,
    input wire spi_slave_pins_en_o,
    input wire link_zero_en_o,
    input wire link_zero_pulldown_o,
    input wire [1:0] link_zero_tx_o,
    input wire link_zero_tx_oe_o,
    input wire ack_token_valid_o,
    input wire [7:0] ack_token_o,
    input wire [31:0] ack_chanend_o,
    input wire boot_done_o,
    input wire run_o,
    input wire [31:0] usercode_o
);
wire [9:0] user_id = otp_security_i[31:22];
default clocking cb @(posedge clk_i); endclocking
default disable iff (!resetn_i);
sequence link_chosen;
    boot_source_o == 3'h4 && $past(boot_source_o) == 3'h0;
endsequence
sequence link_opens;
    !link_zero_en_o [*8] ##[1:20] link_zero_en_o;
endsequence
chk_reset_pulls: assert property ($rose(resetn_i) |-> gpio_pulldown_o [*8])
    else $error("pull-downs released early");
chk_clock_block: assert property (port_clock_block_o == 3'h0)
    else $error("port clock block not zero");
chk_otp_override: assert property (otp_security_i[5] && boot_source_o != 3'h0 |-> boot_source_o == 3'h5)
    else $error("otp boot not taken");
chk_link_strap: assert property (link_zero_en_o |-> boot_source_o == 3'h4)
    else $error("link enabled outside link boot");
chk_spi_pins: assert property (spi_slave_pins_en_o |-> boot_source_o == 3'h3)
    else $error("spi pins enabled outside spi slave boot");
chk_link_delay: assert property (link_chosen |-> link_opens)
    else $error("link enable delay wrong");
chk_link_wires: assert property (link_zero_en_o |-> !link_zero_pulldown_o && link_zero_tx_oe_o && !link_zero_tx_o)
    else $error("link wire state wrong");
chk_ack_end: assert property (ack_token_valid_o |-> ack_token_o == 8'h01 && ack_chanend_o != 32'h0000ff02 ##[0:3] boot_done_o)
    else $error("bad acknowledge token");
chk_run_next: assert property ($rose(boot_done_o) |=> run_o)
    else $error("run not raised after done");
chk_usercode: assert property ($past(resetn_i) |-> usercode_o == {$past(user_id), 6'h0, $past(silicon_rev_i)})
    else $error("usercode wrong");
endmodule // tile_boot_loader_checker
bind tile_boot_loader tile_boot_loader_checker chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .otp_security_i(otp_security_i), .silicon_rev_i(silicon_rev_i),
    .gpio_pulldown_o(gpio_pulldown_o), .port_clock_block_o(port_clock_block_o), .boot_source_o(boot_source_o),
    .spi_slave_pins_en_o(spi_slave_pins_en_o), .link_zero_en_o(link_zero_en_o),
    .link_zero_pulldown_o(link_zero_pulldown_o), .link_zero_tx_o(link_zero_tx_o),
    .link_zero_tx_oe_o(link_zero_tx_oe_o), .ack_token_valid_o(ack_token_valid_o), .ack_token_o(ack_token_o),
    .ack_chanend_o(ack_chanend_o), .boot_done_o(boot_done_o), .run_o(run_o), .usercode_o(usercode_o)
);

// *** verification/boot_host_model.sv ***
/*
 boot host: spi master and link sender.
 assumes the link receive wires have pull-downs and mosi has none.
*/
`timescale 1ns/1ns
module boot_host_model (
    input wire cpol_i,
    output reg ss_n_o,
    output reg sclk_o,
    output reg mosi_o,
    output reg lclk_o,
    output reg [1:0] lrx_o
);
initial begin
    ss_n_o = 1;
    sclk_o = 0;
    mosi_o = 0;
    lclk_o = 0;
    lrx_o = 2'h0;
end
task spi_sel(input on);
    begin
        #400 sclk_o = cpol_i;
        ss_n_o = ~on;
        #400 if (!on) mosi_o = ~mosi_o;
    end
endtask
task spi_bits(input [31:0] d, input integer n);
    integer k;
    begin
        for (k = 0; k < n; k = k + 1) begin
            if (cpol_i) sclk_o = 1'b0;
            mosi_o = d[k];
            #400 sclk_o = 1'b1;
            #400 if (!cpol_i) sclk_o = 1'b0;
        end
    end
endtask
task link_bits(input [31:0] d, input integer n);
    integer k;
    begin
        #37;
        for (k = 0; k < n; k = k + 2) begin
            lrx_o = d[k +: 2];
            #200 lclk_o = 1;
            #400 lclk_o = 0;
            #200;
        end
        lrx_o = 2'h0;
    end
endtask
endmodule // boot_host_model

// *** verification/tb_top.sv ***
/*
 testbench for the tile boot loader: strap, otp, spi slave and link boots.
 assumes the host model drives the spi and link pins.
*/
`timescale 1ns/1ns
`include "tile_boot_regs.vh"
module tb_top;
reg clk_i = 0;
reg resetn_i = 0;
reg [2:0] strap = 3'h0;
reg [31:0] otp = 32'h0;
reg [15:0] rev = 16'h0b0d;
reg cpol = 0;
reg ready = 1;
reg five = 0;
wire ss_n, sclk, mosi, lclk, pd, spi_en, len, lpd, loe, l5, alloc, ackv, pv, done, run;
wire [1:0] lrx, ltx;
wire [2:0] pcb, src;
wire [31:0] ackch, pw, psz, uc;
integer mismatches = 0;
integer checks = 0;
integer cycles = 0;
integer acks = 0;
integer i, k;
reg [31:0] got [$];
tile_boot_loader dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .boot_strap_bit2_i(strap[2]), .boot_strap_bit1_i(strap[1]),
    .boot_strap_bit0_i(strap[0]), .otp_security_i(otp), .silicon_rev_i(rev), .boot_slave_select_pin_i(ss_n),
    .boot_slave_clock_pin_i(sclk), .boot_slave_data_pin_i(mosi), .spi_cpol_i(cpol), .link_five_wire_i(five),
    .link_zero_clk_i(lclk), .link_zero_rx_i(lrx), .prog_ready_i(ready), .gpio_pulldown_o(pd),
    .port_clock_block_o(pcb), .boot_source_o(src), .spi_slave_pins_en_o(spi_en), .link_zero_en_o(len),
    .link_zero_pulldown_o(lpd), .link_zero_tx_o(ltx), .link_zero_tx_oe_o(loe), .link_five_wire_o(l5),
    .chanend0_alloc_o(alloc), .ack_chanend_o(ackch), .ack_token_valid_o(ackv), .ack_token_o(),
    .prog_valid_o(pv), .prog_word_o(pw), .prog_size_o(psz), .boot_done_o(done), .run_o(run), .usercode_o(uc)
);
boot_host_model host (.cpol_i(cpol), .ss_n_o(ss_n), .sclk_o(sclk), .mosi_o(mosi), .lclk_o(lclk), .lrx_o(lrx));
initial forever #50 clk_i = ~clk_i;
task print_verdict;
    begin
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
endtask
always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (pv === 1'b1) got.push_back(pw);
    if (ackv === 1'b1) acks = acks + 1;
    if (cycles == 20000) begin
        mismatches = mismatches + 1;
        print_verdict;
    end
end
task chk(input [31:0] g, input [31:0] e);
    begin
        checks = checks + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    end
endtask
task start(input [2:0] s, input [31:0] o, input c);
    begin
        @(negedge clk_i);
        resetn_i = 0;
        strap = s;
        otp = o;
        cpol = c;
        repeat (3) @(negedge clk_i);
        chk({pd, lpd}, 2'h3);
        resetn_i = 1;
        got.delete();
        acks = 0;
        repeat (140) @(negedge clk_i);
        chk({pd, src}, 4'h8);
        repeat (20) @(negedge clk_i);
        chk(pd, 0);
        chk(pcb, 0);
    end
endtask
task check_image;
    begin
        chk(psz, 2);
        chk(got.size(), 2);
        chk(got[0], 32'hc3a50f81);
        chk(got[1], 32'h00ff1e2d);
        chk({done, run}, 2'h3);
    end
endtask
initial begin
    for (i = 0; i < 5; i = i + 1) begin
        start((i == 4) ? 3'h7 : i[2:0], 32'h0, 0);
        chk(src, (i == 4) ? `SRC_NONE : (i < 2) ? i + 1 : `SRC_SPI_SLAVE);
        chk(len, 0);
    end
    start(`STRAP_LINK, 32'h20, 0);
    chk(src, `SRC_OTP);
    repeat (40) @(negedge clk_i);
    chk(len, 0);
    for (i = 0; i < 2; i = i + 1) begin
        start(i ? `STRAP_SPI_SLAVE_B : `STRAP_SPI_SLAVE_A, 32'ha9400000, i[0]);
        chk(spi_en, 1);
        chk(uc, {10'h2a5, 6'h0, rev});
        host.spi_bits(32'hff, 8);
        host.spi_sel(1);
        host.spi_bits(32'h5, 3);
        host.spi_sel(0);
        host.spi_sel(1);
        host.spi_bits(32'h2, 32);
        host.spi_bits(32'hc3a50f81, 32);
        host.spi_bits(32'h00ff1e2d, 32);
        host.spi_sel(0);
        repeat (20) @(negedge clk_i);
        check_image;
    end
    for (i = 0; i < 2; i = i + 1) begin
        five = i[0];
        start(`STRAP_LINK, 32'h0, 0);
        for (k = 0; k < 60 && len !== 1'b1; k = k + 1) @(negedge clk_i);
        chk(k, 13);
        chk({len, alloc}, 2'h3);
        chk({lpd, loe, ltx, l5}, {4'h4, i[0]});
        ready = 0;
        host.link_bits(i ? `NULL_CHANEND : 32'h00000c02, 32);
        host.link_bits(32'h2, 32);
        host.link_bits(32'hc3a50f81, 32);
        host.link_bits(32'h00ff1e2d, 32);
        @(negedge clk_i);
        ready = 1;
        host.link_bits(32'h0, 32);
        host.link_bits({24'h0, `TOKEN_END}, 8);
        repeat (20) @(negedge clk_i);
        check_image;
        chk(ackch, i ? `NULL_CHANEND : 32'h00000c02);
        chk(acks, 1 - i);
        chk(alloc, 0);
    end
    print_verdict;
end
endmodule // tb_top
